/* File: hw/cmb_pkg.sv */
// Shared constants, types and register map of the CAN message buffer manager
package cmb_pkg;
  localparam int MSG_BYTES = 13;
  localparam int NUM_TX = 3;
  localparam int NUM_FILT = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_RX_BASE = 8'h00;
  localparam logic [3:0] ADDR_TX_PAGE0 = 4'h1;
  localparam logic [3:0] ADDR_TX_PAGE2 = 4'h3;
  localparam logic [3:0] ADDR_LOCAL_PRIORITY_FIELD_OFS = 4'hD;
  localparam logic [7:0] ADDR_RFLG = 8'h40;
  localparam logic [7:0] ADDR_RCTL = 8'h41;
  localparam logic [7:0] ADDR_TFLG = 8'h42;
  localparam logic [7:0] ADDR_TCTL = 8'h43;
  localparam logic [7:0] ADDR_ACTL = 8'h44;
  localparam logic [7:0] ADDR_MCTL = 8'h45;
  localparam logic [5:0] ADDR_PAT_PAGE = 6'h12;
  localparam logic [5:0] ADDR_MSK_PAGE = 6'h13;

  // Field positions
  localparam int RFLG_RXF = 0;
  localparam int RFLG_OVR = 1;
  localparam int RCTL_RXIE = 0;
  localparam int RCTL_OVIE = 1;
  localparam int TFLG_ABORT_ACKNOWLEDGE_FLAG_LSB = 4;
  localparam int TCTL_TXIE_LSB = 4;
  localparam int ACTL_MODE_LSB = 0;
  localparam int ACTL_HIT_LSB = 4;
  localparam int MCTL_LOOP = 0;
  localparam int IDR1_IDE = 3;

  // Compare selects on identifier bytes
  localparam logic [7:0] SEL_FULL = 8'hFF;
  localparam logic [7:0] SEL_STD_IDR1 = 8'hF8;

  // Reset values
  localparam logic [2:0] TXE_RST = 3'h7;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    CMB_FILT_SINGLE = 2'b00,
    CMB_FILT_DUAL = 2'b01,
    CMB_FILT_QUAD = 2'b10,
    CMB_FILT_CLOSED = 2'b11
  } cmb_filt_mode_e;

  typedef enum logic {
    CMB_TX_IDLE = 1'b0,
    CMB_TX_SENDING = 1'b1
  } cmb_tx_state_e;

  // One received byte from the protocol engine
  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [7:0] data;
  } cmb_rx_beat_s;

  // Transmit events from the protocol engine, each a one-cycle pulse
  typedef struct packed {
    logic arb_req;
    logic done_ok;
    logic retry;
  } cmb_tx_evt_s;
endpackage : cmb_pkg

/* File: hw/cmb_buffer_manager.sv */
// CAN message buffer manager: receive FIFO, transmit buffers, acceptance filter
// What this block does
// - Receive is a two-stage FIFO: hidden background buffer, readable foreground buffer.
// - Each receive buffer holds 13 bytes: identifier, control bits and data.
// - Receive-full flag set when foreground holds a good, accepted message.
// - Every frame is written to background while filtering runs, accept or not, unless background holds a frame.
// - Accepted frame copies to foreground only when flag clear; then flag and interrupt.
// - Background can take a new frame right after the previous inter-frame space.
// - Own frames outside loop-back stay in background, no interrupt, no acknowledge.
// - In loop-back own frames are handled like any received frame.
// - After lost arbitration the winning frame is received as normal.
// - Both buffers full and another accepted frame: discard it, flag overrun.
// - While both buffers full, transmit continues and all incoming frames are dropped.
// - Three transmit buffers of 13 bytes, each with an 8-bit local priority.
// - Successful send sets the buffer's empty flag and raises transmit interrupt.
// - Among ready buffers the lowest local priority value is sent first.
// - Priority selection is repeated on every arbitration, retries included.
// - Abort request releases a buffer unless it is being sent: acknowledge, empty.
// - On release the abort acknowledge is 1 if aborted, 0 if sent.
// - Four pattern and four mask bytes; a set mask bit makes that bit don't-care.
// - Acceptance reports a two-bit hit; lowest matching section wins.
// - Single mode: 29-bit extended or 11-bit standard identifier compare, hit zero.
// - Dual mode: two filters on 14 upper extended or 11 standard bits.
// - Quad mode: four filters each comparing the first eight identifier bits.
// - Closed mode: no frame is accepted; only a frame already held in background can still reach the foreground and set receive-full.
// - Flags clear by writing one; clear ignored while the setting condition holds.
module cmb_buffer_manager
  import cmb_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire cmb_rx_beat_s rx_beat,
  input wire logic rx_frame_ok,
  input wire logic rx_own,
  input wire cmb_tx_evt_s tx_evt,
  input wire logic [3:0] tx_rd_idx,
  output logic [7:0] tx_rd_data,
  output logic tx_valid,
  output logic [1:0] tx_sel,
  output logic rx_ack_allow,
  output logic rx_irq,
  output logic tx_irq
);

  logic [7:0] bg_reg [MSG_BYTES];
  logic [7:0] fg_reg [MSG_BYTES];
  logic [7:0] txbuf_reg [NUM_TX][MSG_BYTES];
  logic [7:0] local_priority_field_reg [NUM_TX];
  logic [7:0] pat_reg [NUM_FILT];
  logic [7:0] msk_reg [NUM_FILT];
  // Identifier bytes of the frame on the wire, one per pattern register; captured even
  // while the background is held, so an overrun is judged on the new frame, not the held one
  logic [7:0] id_reg [NUM_FILT];

  logic rxf_reg, rxf_next;
  logic ovr_reg, ovr_next;
  logic bg_full_reg, bg_full_next;
  logic [1:0] bg_hit_reg;
  logic [1:0] hit_reg;
  logic rxie_reg, ovie_reg;
  logic [2:0] txe_reg, txe_next;
  logic [2:0] abort_acknowledge_flag_reg, abort_acknowledge_flag_next;
  logic [2:0] abort_request_flag_reg, abort_request_flag_next;
  logic [2:0] txie_reg;
  cmb_filt_mode_e mode_reg;
  logic loop_reg;
  cmb_tx_state_e tx_state_reg;
  logic [1:0] tx_sel_reg;
  logic tx_valid_reg;
  logic [7:0] rdata_reg;
  logic [7:0] tx_rd_data_reg;
  logic rx_ack_allow_reg, rx_irq_reg, tx_irq_reg;

  function automatic logic byte_match(input logic [7:0] id, input logic [7:0] pat,
                                      input logic [7:0] msk, input logic [7:0] sel);
    return ((id ^ pat) & ~msk & sel) == 8'h00;
  endfunction : byte_match

  // Lowest priority value wins; strict less-than keeps the lower index on ties
  function automatic logic [2:0] pick_buffer(input logic [2:0] ready,
                                             input logic [7:0] p0, input logic [7:0] p1,
                                             input logic [7:0] p2);
    logic found;
    logic [1:0] idx;
    logic [7:0] best;
    logic [7:0] pv [NUM_TX];
    found = 1'b0;
    idx = 2'h0;
    best = 8'hFF;
    pv[0] = p0;
    pv[1] = p1;
    pv[2] = p2;
    for (int i = 0; i < NUM_TX; i++) begin
      if (ready[i] && (!found || pv[i] < best)) begin
        found = 1'b1;
        idx = 2'(i);
        best = pv[i];
      end
    end
    return {found, idx};
  endfunction : pick_buffer

  // Acceptance filter over the identifier bytes of the incoming frame
  wire logic ide = id_reg[1][IDR1_IDE];
  wire logic [7:0] idr1_sel = ide ? SEL_FULL : SEL_STD_IDR1;
  wire logic single_hit = byte_match(id_reg[0], pat_reg[0], msk_reg[0], SEL_FULL)
    & byte_match(id_reg[1], pat_reg[1], msk_reg[1], idr1_sel)
    & (!ide | byte_match(id_reg[2], pat_reg[2], msk_reg[2], SEL_FULL))
    & (!ide | byte_match(id_reg[3], pat_reg[3], msk_reg[3], SEL_FULL));
  wire logic dual_hit0 = byte_match(id_reg[0], pat_reg[0], msk_reg[0], SEL_FULL)
    & byte_match(id_reg[1], pat_reg[1], msk_reg[1], idr1_sel);
  wire logic dual_hit1 = byte_match(id_reg[0], pat_reg[2], msk_reg[2], SEL_FULL)
    & byte_match(id_reg[1], pat_reg[3], msk_reg[3], idr1_sel);
  logic [3:0] quad_hits;
  always_comb begin
    for (int i = 0; i < NUM_FILT; i++) begin
      quad_hits[i] = byte_match(id_reg[0], pat_reg[i], msk_reg[i], SEL_FULL);
    end
  end
  wire logic [3:0] hits = (mode_reg == CMB_FILT_SINGLE) ? {3'h0, single_hit} :
                          (mode_reg == CMB_FILT_DUAL) ? {2'h0, dual_hit1, dual_hit0} :
                          (mode_reg == CMB_FILT_QUAD) ? quad_hits : 4'h0;
  wire logic hit_any = |hits;
  wire logic [1:0] hit_idx = hits[0] ? 2'h0 : hits[1] ? 2'h1 :
                             hits[2] ? 2'h2 : 2'h3;

  // Register decode
  wire logic [3:0] page = reg_addr[7:4];
  wire logic [3:0] ofs = reg_addr[3:0];
  wire logic tx_page = (page >= ADDR_TX_PAGE0) && (page <= ADDR_TX_PAGE2);
  wire logic [1:0] wr_buf = 2'(page - ADDR_TX_PAGE0);
  wire logic tx_data_wr = reg_wr && tx_page && (ofs < 4'(MSG_BYTES)) && txe_reg[wr_buf];
  wire logic tx_local_priority_field_wr = reg_wr && tx_page && (ofs == ADDR_LOCAL_PRIORITY_FIELD_OFS) && txe_reg[wr_buf];
  wire logic wr_rflg = reg_wr && (reg_addr == ADDR_RFLG);
  wire logic wr_rctl = reg_wr && (reg_addr == ADDR_RCTL);
  wire logic wr_tflg = reg_wr && (reg_addr == ADDR_TFLG);
  wire logic wr_tctl = reg_wr && (reg_addr == ADDR_TCTL);
  wire logic wr_actl = reg_wr && (reg_addr == ADDR_ACTL);
  wire logic wr_mctl = reg_wr && (reg_addr == ADDR_MCTL);
  wire logic wr_pat = reg_wr && (reg_addr[7:2] == ADDR_PAT_PAGE);
  wire logic wr_msk = reg_wr && (reg_addr[7:2] == ADDR_MSK_PAGE);

  // Receive path
  wire logic own_blocked = rx_own && !loop_reg;
  wire logic frame_accept = rx_frame_ok && hit_any && !own_blocked;
  wire logic copy_direct = frame_accept && !bg_full_reg && !rxf_reg;
  wire logic hold_bg = frame_accept && !bg_full_reg && rxf_reg;
  wire logic overrun_ev = frame_accept && bg_full_reg;
  // A held frame moves up one cycle after the receive-full flag reads clear
  wire logic drain = bg_full_reg && !rxf_reg;
  wire logic bg_wr = rx_beat.valid && !bg_full_reg
                     && (rx_beat.idx < 4'(MSG_BYTES));
  wire logic id_wr = rx_beat.valid && (rx_beat.idx < 4'(NUM_FILT));
  wire logic clr_rxf = wr_rflg && reg_wdata[RFLG_RXF];
  wire logic clr_ovr = wr_rflg && reg_wdata[RFLG_OVR];

  assign rxf_next = copy_direct || drain || (rxf_reg && !clr_rxf);
  assign ovr_next = overrun_ev || (ovr_reg && !clr_ovr);
  assign bg_full_next = hold_bg || (bg_full_reg && !drain);

  // Transmit path
  wire logic sending = (tx_state_reg == CMB_TX_SENDING);
  // A buffer with an abort pending is never offered to arbitration
  wire logic [2:0] tx_ready = ~txe_reg & ~abort_request_flag_reg;
  wire logic [2:0] pick = pick_buffer(tx_ready, local_priority_field_reg[0], local_priority_field_reg[1], local_priority_field_reg[2]);
  wire logic [2:0] done_set = (sending && tx_evt.done_ok) ? 3'(1 << tx_sel_reg) : 3'h0;
  logic [2:0] abort_grant;
  always_comb begin
    for (int i = 0; i < NUM_TX; i++) begin
      abort_grant[i] = abort_request_flag_reg[i] && !txe_reg[i]
                       && !(sending && tx_sel_reg == 2'(i));
    end
  end
  wire logic [2:0] release_set = done_set | abort_grant;
  wire logic [2:0] sw_clr_txe = wr_tflg ? reg_wdata[2:0] : 3'h0;

  assign txe_next = release_set | (txe_reg & ~sw_clr_txe);
  assign abort_acknowledge_flag_next = abort_grant | (abort_acknowledge_flag_reg & ~done_set);
  // A request on an empty buffer has nothing to abort; kept, it would kill the next load
  assign abort_request_flag_next = (wr_tctl ? (reg_wdata[2:0] & ~txe_reg) : abort_request_flag_reg) & ~release_set;

  // Read mux
  function automatic logic [7:0] read_value(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a[7:4] == ADDR_RX_BASE[7:4] && a[3:0] < 4'(MSG_BYTES)) begin
      v = fg_reg[a[3:0]];
    end else if (a[7:4] >= ADDR_TX_PAGE0 && a[7:4] <= ADDR_TX_PAGE2) begin
      if (a[3:0] < 4'(MSG_BYTES)) begin
        v = txbuf_reg[2'(a[7:4] - ADDR_TX_PAGE0)][a[3:0]];
      end else if (a[3:0] == ADDR_LOCAL_PRIORITY_FIELD_OFS) begin
        v = local_priority_field_reg[2'(a[7:4] - ADDR_TX_PAGE0)];
      end
    end else if (a == ADDR_RFLG) begin
      v[RFLG_RXF] = rxf_reg;
      v[RFLG_OVR] = ovr_reg;
    end else if (a == ADDR_RCTL) begin
      v[RCTL_RXIE] = rxie_reg;
      v[RCTL_OVIE] = ovie_reg;
    end else if (a == ADDR_TFLG) begin
      v[2:0] = txe_reg;
      v[TFLG_ABORT_ACKNOWLEDGE_FLAG_LSB +: 3] = abort_acknowledge_flag_reg;
    end else if (a == ADDR_TCTL) begin
      v[2:0] = abort_request_flag_reg;
      v[TCTL_TXIE_LSB +: 3] = txie_reg;
    end else if (a == ADDR_ACTL) begin
      v[ACTL_MODE_LSB +: 2] = mode_reg;
      v[ACTL_HIT_LSB +: 2] = hit_reg;
    end else if (a == ADDR_MCTL) begin
      v[MCTL_LOOP] = loop_reg;
    end else if (a[7:2] == ADDR_PAT_PAGE) begin
      v = pat_reg[a[1:0]];
    end else if (a[7:2] == ADDR_MSK_PAGE) begin
      v = msk_reg[a[1:0]];
    end
    return v;
  endfunction : read_value

  wire logic [7:0] tx_byte = (tx_rd_idx < 4'(MSG_BYTES)) ?
                             txbuf_reg[tx_sel_reg][tx_rd_idx] : 8'h00;

  // Background buffer: overwritten by every frame while not holding one, filter result irrelevant
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < MSG_BYTES; i++) bg_reg[i] <= BYTE_RST;
    end else if (bg_wr) begin
      bg_reg[rx_beat.idx] <= rx_beat.data;
    end
  end

  // Identifier capture runs on every frame, whatever the state of the background
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_FILT; i++) id_reg[i] <= BYTE_RST;
    end else if (id_wr) begin
      id_reg[rx_beat.idx[1:0]] <= rx_beat.data;
    end
  end

  // Foreground buffer and hit report, loaded together from the background
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < MSG_BYTES; i++) fg_reg[i] <= BYTE_RST;
      hit_reg <= 2'h0;
      bg_hit_reg <= 2'h0;
    end else begin
      if (copy_direct || drain) begin
        for (int i = 0; i < MSG_BYTES; i++) fg_reg[i] <= bg_reg[i];
        hit_reg <= copy_direct ? hit_idx : bg_hit_reg;
      end
      if (hold_bg) begin
        bg_hit_reg <= hit_idx;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxf_reg <= 1'b0;
      ovr_reg <= 1'b0;
      bg_full_reg <= 1'b0;
      txe_reg <= TXE_RST;
      abort_acknowledge_flag_reg <= 3'h0;
      abort_request_flag_reg <= 3'h0;
    end else begin
      rxf_reg <= rxf_next;
      ovr_reg <= ovr_next;
      bg_full_reg <= bg_full_next;
      txe_reg <= txe_next;
      abort_acknowledge_flag_reg <= abort_acknowledge_flag_next;
      abort_request_flag_reg <= abort_request_flag_next;
    end
  end

  // Control registers written by software
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxie_reg <= 1'b0;
      ovie_reg <= 1'b0;
      txie_reg <= 3'h0;
      mode_reg <= CMB_FILT_SINGLE;
      loop_reg <= 1'b0;
      for (int i = 0; i < NUM_FILT; i++) begin
        pat_reg[i] <= BYTE_RST;
        msk_reg[i] <= BYTE_RST;
      end
    end else begin
      if (wr_rctl) begin
        rxie_reg <= reg_wdata[RCTL_RXIE];
        ovie_reg <= reg_wdata[RCTL_OVIE];
      end
      if (wr_tctl) txie_reg <= reg_wdata[TCTL_TXIE_LSB +: 3];
      if (wr_actl) mode_reg <= cmb_filt_mode_e'(reg_wdata[ACTL_MODE_LSB +: 2]);
      if (wr_mctl) loop_reg <= reg_wdata[MCTL_LOOP];
      if (wr_pat) pat_reg[reg_addr[1:0]] <= reg_wdata;
      if (wr_msk) msk_reg[reg_addr[1:0]] <= reg_wdata;
    end
  end

  // Transmit buffers accept writes only while released, so a queued frame stays intact
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int b = 0; b < NUM_TX; b++) begin
        local_priority_field_reg[b] <= BYTE_RST;
        for (int i = 0; i < MSG_BYTES; i++) txbuf_reg[b][i] <= BYTE_RST;
      end
    end else begin
      if (tx_data_wr) txbuf_reg[wr_buf][ofs] <= reg_wdata;
      if (tx_local_priority_field_wr) local_priority_field_reg[wr_buf] <= reg_wdata;
    end
  end

  // Transmit scheduler: reselects on every arbitration request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_reg <= CMB_TX_IDLE;
      tx_sel_reg <= 2'h0;
      tx_valid_reg <= 1'b0;
    end else begin
      unique case (tx_state_reg)
        CMB_TX_IDLE: begin
          if (tx_evt.arb_req && pick[2]) begin
            tx_state_reg <= CMB_TX_SENDING;
            tx_sel_reg <= pick[1:0];
            tx_valid_reg <= 1'b1;
          end
        end
        // A retry drops back to idle so the next arbitration selects afresh
        CMB_TX_SENDING: begin
          if (tx_evt.done_ok || tx_evt.retry) begin
            tx_state_reg <= CMB_TX_IDLE;
            tx_valid_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      tx_rd_data_reg <= 8'h00;
      rx_ack_allow_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
      tx_irq_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? read_value(reg_addr) : 8'h00;
      tx_rd_data_reg <= tx_byte;
      rx_ack_allow_reg <= !own_blocked;
      rx_irq_reg <= (rxf_next && rxie_reg) || (ovr_next && ovie_reg);
      tx_irq_reg <= |(txe_next & txie_reg);
    end
  end

  assign reg_rdata = rdata_reg;
  assign tx_rd_data = tx_rd_data_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_sel = tx_sel_reg;
  assign rx_ack_allow = rx_ack_allow_reg;
  assign rx_irq = rx_irq_reg;
  assign tx_irq = tx_irq_reg;
endmodule : cmb_buffer_manager

/* File: verification/cmb_buffer_manager_sva.sv */
// Port-level assertions for the CAN message buffer manager
module cmb_mgr_chk
  import cmb_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_own,
  input wire cmb_tx_evt_s tx_evt,
  input wire logic [3:0] tx_rd_idx,
  input wire logic [7:0] tx_rd_data,
  input wire logic tx_valid,
  input wire logic [1:0] tx_sel,
  input wire logic rx_ack_allow,
  input wire logic rx_irq,
  input wire logic tx_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  // Acknowledge output still holds its reset value one edge after release
  property p_ack_other;
    $past(nrst) && !$past(rx_own) |-> rx_ack_allow;
  endproperty
  a_ack_other: assert property (p_ack_other) else $error("foreign frame not acked");
  property p_grant;
    $rose(tx_valid) |-> $past(tx_evt.arb_req) && tx_sel != 2'h3;
  endproperty
  a_grant: assert property (p_grant) else $error("send without arbitration");
  property p_tx_hold;
    tx_valid && !tx_evt.done_ok && !tx_evt.retry |=> tx_valid && $stable(tx_sel);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame in flight dropped");
  property p_tx_end;
    tx_valid && (tx_evt.done_ok || tx_evt.retry) |=> !tx_valid;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("buffer not released");
  property p_txrd_range;
    tx_rd_idx > 4'hC |=> tx_rd_data == 8'h00;
  endproperty
  a_txrd_range: assert property (p_txrd_range) else $error("byte beyond buffer");
  // A flag clear drops the line one edge after the write, an enable write two edges after
  property p_rx_irq_fall;
    $fell(rx_irq) |-> $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_rx_irq_fall: assert property (p_rx_irq_fall) else $error("rx irq dropped alone");
  property p_tx_irq_fall;
    $fell(tx_irq) |-> $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_tx_irq_fall: assert property (p_tx_irq_fall) else $error("tx irq dropped alone");
  c_send: cover property ($rose(tx_valid));
  c_retry: cover property (tx_valid && tx_evt.retry);
  c_rx_irq: cover property ($rose(rx_irq));
endmodule : cmb_mgr_chk

bind cmb_buffer_manager cmb_mgr_chk chk_u (
  .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_own(rx_own), .tx_evt(tx_evt), .tx_rd_idx(tx_rd_idx),
  .tx_rd_data(tx_rd_data), .tx_valid(tx_valid), .tx_sel(tx_sel),
  .rx_ack_allow(rx_ack_allow), .rx_irq(rx_irq), .tx_irq(tx_irq)
);

/* File: verification/cmb_can_engine_model.sv */
// Behavioural CAN protocol engine and bus as seen by the buffer manager
module cmb_can_engine_model
  import cmb_pkg::*;
(
  input wire logic core_clk,
  output cmb_rx_beat_s rx_beat,
  output logic rx_frame_ok,
  output logic rx_own,
  output cmb_tx_evt_s tx_evt,
  output logic [3:0] tx_rd_idx,
  input wire logic [7:0] tx_rd_data,
  input wire logic tx_valid,
  input wire logic [1:0] tx_sel,
  input wire logic rx_ack_allow
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ack_seen;
  initial begin
    rx_beat = '0;
    rx_frame_ok = 1'b0;
    rx_own = 1'b0;
    tx_evt = '0;
    tx_rd_idx = 4'hF;
    ack_seen = 1'b0;
  end
  // Standard frame: byte 0 carries the id, byte 1 is zero, payload is d xor index
  task automatic send_frame(input logic [7:0] id0, input logic [7:0] d, input logic own);
    logic [7:0] b;
    for (int k = 0; k < MSG_BYTES; k++) begin
      @(posedge core_clk);
      rx_own <= own;
      b = (k == 0) ? id0 : ((k == 1) ? 8'h00 : (d ^ 8'(k)));
      rx_beat <= '{valid: 1'b1, idx: 4'(k), data: b};
    end
    @(posedge core_clk);
    // Idle data line toggles so stale bytes cannot pass as valid
    rx_beat <= '{valid: 1'b0, idx: 4'hF, data: ~b};
    rx_frame_ok <= 1'b1;
    ack_seen = rx_ack_allow;
    @(posedge core_clk);
    rx_frame_ok <= 1'b0;
    rx_own <= 1'b0;
  endtask : send_frame
  task automatic arbitrate(output logic v, output logic [1:0] s);
    @(posedge core_clk);
    tx_evt <= '{arb_req: 1'b1, done_ok: 1'b0, retry: 1'b0};
    @(posedge core_clk);
    tx_evt <= '0;
    #1;
    v = tx_valid;
    s = tx_sel;
  endtask : arbitrate
  // A failed attempt leaves the engine free to receive the winning frame
  task automatic finish(input logic ok);
    @(posedge core_clk);
    tx_evt <= '{arb_req: 1'b0, done_ok: ok, retry: !ok};
    @(posedge core_clk);
    tx_evt <= '0;
  endtask : finish
  task automatic read_byte(input logic [3:0] i, output logic [7:0] d);
    @(posedge core_clk);
    tx_rd_idx <= i;
    @(posedge core_clk);
    #1;
    d = tx_rd_data;
  endtask : read_byte
endmodule : cmb_can_engine_model

/* File: verification/tb.sv */
// Self-checking testbench for the CAN message buffer manager
module tb
  import cmb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CYCLE_LIMIT = 20000;
  logic core_clk, nrst, reg_wr, reg_rd, rx_frame_ok, rx_own, tx_valid;
  logic rx_ack_allow, rx_irq, tx_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_rd_data;
  logic [3:0] tx_rd_idx;
  logic [1:0] tx_sel;
  cmb_rx_beat_s rx_beat;
  cmb_tx_evt_s tx_evt;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  cmb_buffer_manager dut_u (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_beat(rx_beat),
    .rx_frame_ok(rx_frame_ok), .rx_own(rx_own), .tx_evt(tx_evt), .tx_rd_idx(tx_rd_idx),
    .tx_rd_data(tx_rd_data), .tx_valid(tx_valid), .tx_sel(tx_sel),
    .rx_ack_allow(rx_ack_allow), .rx_irq(rx_irq), .tx_irq(tx_irq)
  );
  cmb_can_engine_model eng_u (
    .core_clk(core_clk), .rx_beat(rx_beat), .rx_frame_ok(rx_frame_ok), .rx_own(rx_own),
    .tx_evt(tx_evt), .tx_rd_idx(tx_rd_idx), .tx_rd_data(tx_rd_data),
    .tx_valid(tx_valid), .tx_sel(tx_sel), .rx_ack_allow(rx_ack_allow)
  );
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, what);
  endtask : rdc
  task automatic t_reset;
    rdc(ADDR_TFLG, 8'h07, "txe reset");
    rdc(ADDR_RFLG, 8'h00, "rx flags reset");
    rdc(ADDR_ACTL, 8'h00, "filter reset");
    wr(8'h7F, 8'hFF);
    rdc(8'h7F, 8'h00, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_rx_fifo;
    wr(ADDR_RCTL, 8'h03);
    eng_u.send_frame(8'h00, 8'hA0, 1'b0);
    rdc(ADDR_RFLG, 8'h01, "rxf set");
    rdc(8'h0C, 8'hAC, "fg last byte");
    check({7'h00, rx_irq}, 8'h01, "rx irq");
    eng_u.send_frame(8'h00, 8'hB0, 1'b0);
    eng_u.send_frame(8'h02, 8'hD0, 1'b0);
    rdc(ADDR_RFLG, 8'h01, "rejected no overrun");
    eng_u.send_frame(8'h00, 8'hC0, 1'b0);
    rdc(ADDR_RFLG, 8'h03, "overrun");
    rdc(8'h02, 8'hA2, "fg kept");
    wr(ADDR_RFLG, 8'h03);
    repeat (2) @(posedge core_clk);
    rdc(ADDR_RFLG, 8'h01, "held copied");
    rdc(8'h02, 8'hB2, "third dropped");
    wr(ADDR_RFLG, 8'h01);
    rdc(ADDR_RFLG, 8'h00, "rx freed");
    $display("test rx_fifo done");
  endtask : t_rx_fifo
  task automatic t_filter;
    logic [7:0] ids [3] = '{8'h11, 8'h22, 8'h44};
    logic [7:0] hits [3] = '{8'h02, 8'h12, 8'h32};
    logic [7:0] pats [4] = '{8'h11, 8'h22, 8'h22, 8'h44};
    wr({ADDR_MSK_PAGE, 2'h0}, 8'h01);
    eng_u.send_frame(8'h01, 8'h10, 1'b0);
    rdc(ADDR_RFLG, 8'h01, "mask bit ignored");
    wr(ADDR_RFLG, 8'h01);
    eng_u.send_frame(8'h02, 8'h10, 1'b0);
    rdc(ADDR_RFLG, 8'h00, "id miss");
    wr(ADDR_ACTL, 8'h03);
    eng_u.send_frame(8'h00, 8'h10, 1'b0);
    rdc(ADDR_RFLG, 8'h00, "closed");
    wr(ADDR_ACTL, 8'h01);
    wr({ADDR_PAT_PAGE, 2'h2}, 8'h33);
    eng_u.send_frame(8'h33, 8'h10, 1'b0);
    rdc(ADDR_ACTL, 8'h11, "dual hit");
    wr(ADDR_RFLG, 8'h01);
    wr(ADDR_ACTL, 8'h02);
    for (int i = 0; i < NUM_FILT; i++) wr({ADDR_PAT_PAGE, 2'(i)}, pats[i]);
    // Filters 1 and 2 both match 0x22, so the lower section must be named
    for (int i = 0; i < 3; i++) begin
      eng_u.send_frame(ids[i], 8'h10, 1'b0);
      rdc(ADDR_ACTL, hits[i], "quad hit");
      wr(ADDR_RFLG, 8'h01);
    end
    wr(ADDR_ACTL, 8'h00);
    wr({ADDR_PAT_PAGE, 2'h1}, 8'h00);
    $display("test filter done");
  endtask : t_filter
  task automatic t_own;
    eng_u.send_frame(8'h11, 8'h20, 1'b1);
    check({7'h00, eng_u.ack_seen}, 8'h00, "own acked");
    rdc(ADDR_RFLG, 8'h00, "own kept out");
    wr(ADDR_MCTL, 8'h01);
    eng_u.send_frame(8'h11, 8'h30, 1'b1);
    check({7'h00, eng_u.ack_seen}, 8'h01, "loop ack");
    rdc(8'h02, 8'h32, "loop copy");
    wr(ADDR_RFLG, 8'h01);
    wr(ADDR_MCTL, 8'h00);
    $display("test own done");
  endtask : t_own
  task automatic t_tx;
    logic v;
    logic [1:0] s;
    logic [7:0] d;
    wr(8'h1D, 8'h05);
    wr(8'h2D, 8'h03);
    wr(8'h3D, 8'h03);
    wr(8'h20, 8'h5A);
    wr(ADDR_TFLG, 8'h07);
    wr(ADDR_TCTL, 8'h70);
    eng_u.arbitrate(v, s);
    check({5'h00, v, s}, 8'h05, "tie to lower");
    eng_u.read_byte(4'h0, d);
    check(d, 8'h5A, "tx byte");
    eng_u.finish(1'b1);
    rdc(ADDR_TFLG, 8'h02, "sent released");
    check({7'h00, tx_irq}, 8'h01, "tx irq");
    eng_u.arbitrate(v, s);
    check({5'h00, v, s}, 8'h06, "reselect");
    wr(ADDR_TCTL, 8'h71);
    rdc(ADDR_TFLG, 8'h13, "abort granted");
    eng_u.finish(1'b0);
    eng_u.send_frame(8'h11, 8'h40, 1'b0);
    rdc(ADDR_RFLG, 8'h01, "winner received");
    wr(ADDR_RFLG, 8'h01);
    eng_u.arbitrate(v, s);
    check({5'h00, v, s}, 8'h06, "retry reselect");
    eng_u.finish(1'b1);
    rdc(ADDR_TFLG, 8'h17, "all released");
    wr(ADDR_TCTL, 8'h00);
    $display("test tx done");
  endtask : t_tx
  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_rx_fifo();
    t_filter();
    t_own();
    t_tx();
    repeat (4) @(posedge core_clk);
    end_sim();
  end
endmodule : tb
